// ---- rtl/audio_dma_address_status.sv ----
// Audio DMA address and status registers with an AHB-Lite slave.
// Assumes one AHB-Lite master, word transfers, and FIFO flags that are
// synchronous to clk_sys.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module audio_dma_address_status
	import audio_dma_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        record_word,
	input  wire logic        playback_word,
	input  wire logic        record_fifo_full,
	input  wire logic        playback_fifo_empty,
	output logic      [31:0] record_dma_address,
	output logic      [31:0] playback_dma_address,
	output logic             irq
);

	// ************************************************************
	// Reset synchroniser
	// ************************************************************
	logic [sync_stages-1:0] rst_pipe;
	logic                   rst_n;

	// Release is synchronised so no register sees a runt reset edge.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_pipe <= '0;
		end else begin
			rst_pipe <= {rst_pipe[sync_stages-2:0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[sync_stages-1];

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [31:0] record_base_address;
	logic [31:0] record_buffer_length;
	logic [31:0] playback_base_address;
	logic [31:0] playback_buffer_length;
	logic [1:0]  record_flags;
	logic [1:0]  playback_flags;
	logic [3:0]  irq_mask;
	logic        record_full_seen;
	logic        playback_empty_seen;

	// ************************************************************
	// AHB-Lite address phase capture
	// ************************************************************
	logic        wr_pend;
	logic        rd_pend;
	logic [31:0] pend_addr;
	logic        take;
	logic        restart_record;
	logic        restart_playback;

	assign take = hsel && hready && htrans[1];

	// Latch the address phase; the data phase follows with no wait.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			pend_addr <= zero_reset;
		end else begin
			wr_pend   <= take && hwrite;
			rd_pend   <= take && !hwrite;
			if (take) begin
				pend_addr <= haddr;
			end
		end
	end

	// The slave never stalls and never errors.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Write-data strobe for one register offset.
	function automatic logic wr_hit(input logic [31:0] off);
		wr_hit = wr_pend && (pend_addr == off);
	endfunction

	// ************************************************************
	// Software-owned registers
	// ************************************************************
	// Only the CPU changes base and length; the pointers never do.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			record_base_address    <= zero_reset;
			record_buffer_length   <= zero_reset;
			playback_base_address  <= zero_reset;
			playback_buffer_length <= zero_reset;
			irq_mask               <= 4'h0;
		end else begin
			if (wr_hit(record_base_address_off)) begin
				record_base_address <= hwdata;
			end
			if (wr_hit(record_buffer_length_off)) begin
				record_buffer_length <= hwdata;
			end
			if (wr_hit(playback_base_address_off)) begin
				playback_base_address <= hwdata;
			end
			if (wr_hit(playback_buffer_length_off)) begin
				playback_buffer_length <= hwdata;
			end
			if (wr_hit(irq_mask_off)) begin
				irq_mask <= hwdata[3:0];
			end
		end
	end

	// Writing a base reloads that path's pointer so it starts clean.
	// The reload waits one edge: in the data phase the base register
	// still holds the old value, and reloading then would lose the new.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			restart_record   <= 1'b0;
			restart_playback <= 1'b0;
		end else begin
			restart_record   <= wr_hit(record_base_address_off);
			restart_playback <= wr_hit(playback_base_address_off);
		end
	end

	// ************************************************************
	// Address pointers
	// ************************************************************
	dma_event_if record_ev ();
	dma_event_if playback_ev ();

	dma_pointer u_record (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.restart (restart_record),
		.step    (record_word),
		.base    (record_base_address),
		.length  (record_buffer_length),
		.ev      (record_ev.source)
	);

	dma_pointer u_playback (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.restart (restart_playback),
		.step    (playback_word),
		.base    (playback_base_address),
		.length  (playback_buffer_length),
		.ev      (playback_ev.source)
	);

	// Current addresses are driven to the memory side from flops.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			record_dma_address   <= zero_reset;
			playback_dma_address <= zero_reset;
		end else begin
			record_dma_address   <= record_ev.current;
			playback_dma_address <= playback_ev.current;
		end
	end

	// ************************************************************
	// Sticky status flags and registered FIFO level bits
	// ************************************************************
	// Next flag value: a new event wins over a same-cycle clear.
	function automatic logic [1:0] next_flags(
		input logic [1:0] cur,
		input logic       clr_en,
		input logic [1:0] clr,
		input logic       mid,
		input logic       fin
	);
		logic [1:0] kept;
		kept = clr_en ? (cur & ~clr) : cur;
		next_flags = kept | {fin, mid};
	endfunction

	// Record flags.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			record_flags <= 2'h0;
		end else begin
			record_flags <= next_flags(record_flags,
				wr_hit(record_status_off), hwdata[1:0],
				record_ev.hit_middle, record_ev.hit_end);
		end
	end

	// Playback flags.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			playback_flags <= 2'h0;
		end else begin
			playback_flags <= next_flags(playback_flags,
				wr_hit(playback_status_off), hwdata[1:0],
				playback_ev.hit_middle, playback_ev.hit_end);
		end
	end

	// FIFO levels registered; playback empty reads one after reset.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			record_full_seen    <= 1'b0;
			playback_empty_seen <= 1'b1;
		end else begin
			record_full_seen    <= record_fifo_full;
			playback_empty_seen <= playback_fifo_empty;
		end
	end

	// ************************************************************
	// Read data and interrupt
	// ************************************************************
	logic [31:0] record_status;
	logic [31:0] playback_status;
	logic [31:0] next_rdata;

	// Upper bits are reserved and read as zero.
	assign record_status = {29'h0, record_full_seen, record_flags};
	assign playback_status = {29'h0, playback_empty_seen, playback_flags};

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		next_rdata = zero_reset;
		unique case (haddr)
			record_base_address_off:      next_rdata = record_base_address;
			record_buffer_length_off:     next_rdata = record_buffer_length;
			record_current_address_off:   next_rdata = record_ev.current;
			record_status_off:            next_rdata = record_status;
			playback_base_address_off:    next_rdata = playback_base_address;
			playback_buffer_length_off:   next_rdata = playback_buffer_length;
			playback_current_address_off: next_rdata = playback_ev.current;
			playback_status_off:          next_rdata = playback_status;
			irq_mask_off:                 next_rdata = {28'h0, irq_mask};
			default:                      next_rdata = zero_reset;
		endcase
	end

	// Read data is captured at the address phase edge so it stands in
	// the data phase straight from a flop.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= zero_reset;
		end else if (take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// Interrupt is the OR of unmasked sticky flags, one cycle late.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |({playback_flags, record_flags} & irq_mask);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	// Record status reserved bits are checked on the read data the bus really sees.
	chk_rec_status_rsvd: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		take && !hwrite && haddr == record_status_off |=>
		hrdata[31:3] == 29'h0)
		else $error("record status reserved bits set");

	chk_rec_full_bit: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		record_status[fifo_bit] == $past(record_fifo_full))
		else $error("record full bit wrong");

	chk_rec_end_sticky: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		record_flags[end_bit] && !(wr_hit(record_status_off)
		&& hwdata[end_bit]) |=> record_flags[end_bit])
		else $error("record end flag lost");

	chk_rec_mid_set: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		record_ev.hit_middle |=> record_flags[middle_bit])
		else $error("record middle flag not set");

	chk_pb_empty_bit: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		playback_status[fifo_bit] == $past(playback_fifo_empty))
		else $error("playback empty bit wrong");

	chk_pb_end_set: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		playback_ev.hit_end |=> playback_flags[end_bit])
		else $error("playback end flag not set");

	chk_pb_mid_clear: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		$fell(playback_flags[middle_bit]) |->
		$past(wr_pend && pend_addr == playback_status_off)
		&& $past(hwdata[middle_bit]))
		else $error("playback middle flag cleared without write");

	chk_pb_base_write: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		wr_hit(playback_base_address_off) |=>
		playback_base_address == $past(hwdata))
		else $error("playback base not written");

	chk_pb_len_write: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		wr_hit(playback_buffer_length_off) |=>
		playback_buffer_length == $past(hwdata))
		else $error("playback length not written");

	// The delayed reload must pick up the newly written base.
	chk_rec_base_reload: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		restart_record |=>
		record_ev.current == $past(record_base_address))
		else $error("record pointer not reloaded to base");

	chk_irq_follow: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		irq == $past(|({playback_flags, record_flags} & irq_mask)))
		else $error("interrupt does not follow flags");

endmodule // audio_dma_address_status

// ---- rtl/audio_dma_pkg.sv ----
// Package of register offsets, field positions and reset values.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package audio_dma_pkg;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [31:0] record_base_address_off      = 32'hfff09008;
	localparam logic [31:0] record_buffer_length_off     = 32'hfff0900c;
	localparam logic [31:0] record_current_address_off   = 32'hfff09010;
	localparam logic [31:0] record_status_off            = 32'hfff09014;
	localparam logic [31:0] playback_base_address_off    = 32'hfff09018;
	localparam logic [31:0] playback_buffer_length_off   = 32'hfff0901c;
	localparam logic [31:0] playback_current_address_off = 32'hfff09020;
	localparam logic [31:0] playback_status_off          = 32'hfff09024;
	localparam logic [31:0] irq_mask_off                 = 32'hfff09040;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          middle_bit           = 0;
	localparam int          end_bit              = 1;
	localparam int          fifo_bit             = 2;
	localparam logic [31:0] zero_reset           = 32'h00000000;
	localparam logic [31:0] playback_status_rst  = 32'h00000004;
	localparam logic [31:0] word_step            = 32'h00000004;
	localparam int          sync_stages          = 2;

endpackage

// ---- rtl/dma_event_if.sv ----
// Interface carrying one path's pointer events to the top module.
// Assumes a single clock domain; the events are one-cycle pulses.
`timescale 1ns/1ps
interface dma_event_if;
	logic        hit_middle;
	logic        hit_end;
	logic [31:0] current;

	modport source (output hit_middle, output hit_end, output current);
	modport sink   (input hit_middle, input hit_end, input current);
endinterface

// ---- rtl/dma_pointer.sv ----
// One path's ring-buffer address pointer with middle and end detect.
// Assumes base and length are set by software while the path is idle.
`timescale 1ns/1ps
module dma_pointer
	import audio_dma_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        restart,
	input  wire logic        step,
	input  wire logic [31:0] base,
	input  wire logic [31:0] length,
	dma_event_if.source      ev
);

	logic [31:0] addr;
	logic [31:0] next_addr;
	logic [31:0] mid_addr;
	logic [31:0] end_addr;

	// Middle is base plus half the length, end is base plus length.
	assign mid_addr = base + {1'b0, length[31:1]};
	assign end_addr = base + length;
	assign next_addr = addr + word_step;

	// A step landing on the end wraps back to base, giving a ring.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr <= zero_reset;
		end else if (restart) begin
			addr <= base;
		end else if (step) begin
			if (next_addr == end_addr) begin
				addr <= base;
			end else begin
				addr <= next_addr;
			end
		end
	end

	// Events pulse in the cycle the step reaches the address.
	assign ev.hit_middle = step && !restart && (next_addr == mid_addr);
	assign ev.hit_end    = step && !restart && (next_addr == end_addr);
	assign ev.current    = addr;

	chk_ring_wrap: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		ev.hit_end |=> addr == $past(base))
		else $error("pointer did not wrap to base");

endmodule // dma_pointer

// ---- sim/dma_side_model.sv ----
// Model of the memory-bus side: word strobes and FIFO level flags.
// Assumes the bench calls its tasks and shares clk_sys with the design.
`timescale 1ns/1ps
module dma_side_model (
	input  wire logic clk_sys,
	output logic      record_word,
	output logic      playback_word,
	output logic      record_fifo_full,
	output logic      playback_fifo_empty
);
	// ************************************************************
	// Idle levels
	// ************************************************************
	// An empty playback FIFO and an idle record FIFO after power-up.
	initial begin
		record_word         = 1'b0;
		playback_word       = 1'b0;
		record_fifo_full    = 1'b0;
		playback_fifo_empty = 1'b1;
	end

	// ************************************************************
	// Stimulus tasks
	// ************************************************************
	// One word strobe a cycle, back to back, the harshest rate.
	task automatic move_words(input logic pb, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			record_word   <= ~pb;
			playback_word <= pb;
		end
		@(posedge clk_sys);
		record_word   <= 1'b0;
		playback_word <= 1'b0;
	endtask

	// Levels change at a clock edge, as a real FIFO flag would.
	task automatic set_fifo(input logic full, input logic empty);
		@(posedge clk_sys);
		record_fifo_full    <= full;
		playback_fifo_empty <= empty;
	endtask
endmodule // dma_side_model

// ---- sim/testbench.sv ----
// Self-checking bench for the audio DMA address and status block.
// Assumes the rtl sources and sim/dma_side_model.sv are compiled first.
`timescale 1ns/1ps
module testbench
	import audio_dma_pkg::*;
;
	logic        clk_sys;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        record_word;
	logic        playback_word;
	logic        record_fifo_full;
	logic        playback_fifo_empty;
	logic [31:0] record_dma_address;
	logic [31:0] playback_dma_address;
	logic        irq;
	int          n_fail;
	int          checked;

	// ************************************************************
	// Clock, instances and watchdog
	// ************************************************************
	// A 50 ns period gives the 20 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	audio_dma_address_status u_audio_dma_address_status (
		.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .record_word(record_word),
		.playback_word(playback_word), .record_fifo_full(record_fifo_full),
		.playback_fifo_empty(playback_fifo_empty),
		.record_dma_address(record_dma_address),
		.playback_dma_address(playback_dma_address), .irq(irq));

	dma_side_model u_dma_side_model (
		.clk_sys(clk_sys), .record_word(record_word),
		.playback_word(playback_word), .record_fifo_full(record_fifo_full),
		.playback_fifo_empty(playback_fifo_empty));

	// The tests need well under a thousand cycles; this cuts a hang short.
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		report_and_stop();
	end

	// ************************************************************
	// Bus and compare tasks
	// ************************************************************
	task automatic report_and_stop();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Address phase held until hready is seen high; stale data inverted.
	task automatic addr_phase(input logic [31:0] a, input logic w);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel   <= 1'b0;
		htrans <= 2'h0;
	endtask

	task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
		addr_phase(a, 1'b1);
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
	endtask

	// Read data and response are taken at the edge that ends the data phase.
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
		input string what);
		addr_phase(a, 1'b0);
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		check(what, exp, hrdata);
		check("hresp", 32'h00000000, {31'h0, hresp});
	endtask

	// The interrupt output is registered behind the flags and the mask.
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic reset_scenario();
		rd_chk(record_base_address_off, zero_reset, "rec_base");
		rd_chk(record_buffer_length_off, zero_reset, "rec_len");
		rd_chk(record_current_address_off, zero_reset, "rec_cur");
		rd_chk(record_status_off, zero_reset, "rec_status");
		rd_chk(playback_base_address_off, zero_reset, "pb_base");
		rd_chk(playback_buffer_length_off, zero_reset, "pb_len");
		rd_chk(playback_current_address_off, zero_reset, "pb_cur");
		rd_chk(playback_status_off, playback_status_rst, "pb_st");
		rd_chk(irq_mask_off, zero_reset, "irq_mask");
		rd_chk(32'hfff09030, zero_reset, "unmapped");
		irq_chk(1'b0);
	endtask

	// Read-only places must ignore writes, even of all ones.
	task automatic rw_scenario();
		ahb_write(record_base_address_off, 32'h5a5aa5a4);
		ahb_write(record_buffer_length_off, 32'hfffffffc);
		ahb_write(playback_base_address_off, 32'h12345678);
		ahb_write(playback_buffer_length_off, 32'h87654320);
		ahb_write(record_current_address_off, 32'hffffffff);
		ahb_write(playback_current_address_off, 32'hffffffff);
		ahb_write(record_status_off, 32'hfffffffc);
		ahb_write(playback_status_off, 32'h00000004);
		ahb_write(32'hfff09030, 32'hffffffff);
		rd_chk(record_base_address_off, 32'h5a5aa5a4, "rec_base");
		rd_chk(record_buffer_length_off, 32'hfffffffc, "rec_len");
		rd_chk(playback_base_address_off, 32'h12345678, "pb_base");
		rd_chk(playback_buffer_length_off, 32'h87654320, "pb_len");
		rd_chk(record_current_address_off, 32'h5a5aa5a4, "rec_cur");
		rd_chk(playback_current_address_off, 32'h12345678, "pb_cur");
		rd_chk(record_status_off, zero_reset, "rec_status");
		rd_chk(playback_status_off, 32'h00000004, "pb_status");
		rd_chk(32'hfff09030, zero_reset, "unmapped");
	endtask

	// Eight-word ring: middle after four strobes, wrap after eight.
	task automatic path_scenario(input logic pb, input logic [31:0] b_off,
		input logic [31:0] l_off, input logic [31:0] c_off,
		input logic [31:0] s_off, input logic [31:0] fb,
		input logic [31:0] mask);
		logic [31:0] base;
		base = pb ? 32'h00020000 : 32'h00010000;
		ahb_write(l_off, 32'h00000020);
		ahb_write(b_off, base);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("port_addr", base,
			pb ? playback_dma_address : record_dma_address);
		u_dma_side_model.move_words(pb, 3);
		rd_chk(s_off, fb, "st_early");
		u_dma_side_model.move_words(pb, 1);
		rd_chk(c_off, base + 32'h10, "cur_mid");
		rd_chk(s_off, fb | 32'h1, "st_mid");
		u_dma_side_model.move_words(pb, 3);
		rd_chk(c_off, base + 32'h1c, "cur_last");
		rd_chk(s_off, fb | 32'h1, "st_last");
		u_dma_side_model.move_words(pb, 1);
		rd_chk(c_off, base, "cur_wrap");
		rd_chk(s_off, fb | 32'h3, "st_end");
		irq_chk(1'b0);
		ahb_write(irq_mask_off, mask);
		irq_chk(1'b1);
		ahb_write(s_off, 32'h00000000);
		rd_chk(s_off, fb | 32'h3, "st_zero");
		ahb_write(s_off, 32'h00000001);
		rd_chk(s_off, fb | 32'h2, "st_clr_mid");
		irq_chk(1'b1);
		ahb_write(s_off, 32'h00000002);
		rd_chk(s_off, fb, "st_clr_end");
		irq_chk(1'b0);
		ahb_write(irq_mask_off, zero_reset);
	endtask

	// The level bits follow the FIFO flags and ignore a written one.
	task automatic fifo_scenario();
		u_dma_side_model.set_fifo(1'b1, 1'b0);
		ahb_write(record_status_off, 32'h00000004);
		rd_chk(record_status_off, 32'h00000004, "rec_full");
		rd_chk(playback_status_off, zero_reset, "pb_not_empty");
		u_dma_side_model.set_fifo(1'b0, 1'b1);
		rd_chk(record_status_off, zero_reset, "rec_not_full");
		rd_chk(playback_status_off, 32'h00000004, "pb_empty");
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	// Reset held three cycles; first transfer waits out the synchroniser.
	initial begin
		n_fail  = 0;
		checked = 0;
		arst_n  = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'b0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset_scenario();
		rw_scenario();
		path_scenario(1'b0, record_base_address_off,
			record_buffer_length_off, record_current_address_off,
			record_status_off, 32'h0, 32'h3);
		path_scenario(1'b1, playback_base_address_off,
			playback_buffer_length_off, playback_current_address_off,
			playback_status_off, 32'h4, 32'hc);
		fifo_scenario();
		report_and_stop();
	end
endmodule // testbench
